/* hdl/rsw_pkg.sv */
package rsw_pkg;

    // base timing; the noise filter is a least time, so it rounds up
    localparam int CLK_PERIOD_NS   = 8;
    localparam int MCLEAR_FILTER_NS  = 100;
    localparam int MCLEAR_FILTER_CYC = (MCLEAR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_W          = 4;

    localparam int PC_W            = 13;
    localparam int IRQ_W           = 8;
    localparam logic [PC_W-1:0] IRQ_VECTOR_ADDR = 13'h0004;
    localparam logic [PC_W-1:0] PC_STEP         = 13'h0001;

    typedef struct packed {
        logic timeout_status_bit;
        logic powerdown_status_bit;
    } rsw_status_t;

    typedef struct packed {
        logic [IRQ_W-1:0] flags;
        logic [IRQ_W-1:0] enables;
    } rsw_irq_t;

    // status values written by the events that load a fixed status
    localparam rsw_status_t STAT_POR        = 2'b11;
    localparam rsw_status_t STAT_BROWN        = 2'b11;
    localparam rsw_status_t STAT_MCLEAR_SLEEP = 2'b10;
    localparam rsw_status_t STAT_WDOG_WAKE    = 2'b00;
    localparam rsw_status_t STAT_SLEEP        = 2'b10;
    localparam rsw_status_t STAT_WDOG_CLEAR   = 2'b11;

    typedef enum logic [5:0] {
        CAUSE_NONE       = 6'h00,
        CAUSE_POR        = 6'h01,
        CAUSE_BROWN        = 6'h02,
        CAUSE_MCLEAR_RUN   = 6'h04,
        CAUSE_MCLEAR_SLEEP = 6'h08,
        CAUSE_WDOG_RESET   = 6'h10,
        CAUSE_WDOG_WAKE    = 6'h20
    } rsw_cause_t;

    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_SLEEP = 3'b010,
        ST_WAKE  = 3'b100
    } rsw_state_t;

    function automatic logic rsw_irq_pending(input rsw_irq_t irq);
        rsw_irq_pending = |(irq.flags & irq.enables);
    endfunction

endpackage

/* hdl/rsw_master_clear_pin_filter.sv */
`timescale 1ns/1ps
module rsw_clear_filter
    import rsw_pkg::*;
(
    input  wire logic i_clock,
    input  wire logic i_reset,
    input  wire logic i_pin_n,
    output logic      o_clear_active
);
    logic [FILT_W-1:0] cnt_reg;
    logic [FILT_W-1:0] cnt_next;
    logic              out_next;
    wire  logic        differs = (!i_pin_n) != o_clear_active;
    wire  logic        settled = cnt_reg == FILT_W'(MCLEAR_FILTER_CYC - 1);

    // a level must differ for the full filter time before the output follows
    assign cnt_next = (!differs || settled) ? '0 : cnt_reg + FILT_W'(1);
    assign out_next = (differs && settled) ? !i_pin_n : o_clear_active;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            cnt_reg        <= '0;
            o_clear_active <= 1'b0;
        end else begin
            cnt_reg        <= cnt_next;
            o_clear_active <= out_next;
        end
    end

    a_filter_glitch: assert property (@(posedge i_clock) disable iff (i_reset)
        $changed(o_clear_active) |-> $past(settled) && $past(differs))
        else $error("filter output moved before the filter time elapsed");

endmodule

/* hdl/rsw_reset_sleep_wake.sv */
`timescale 1ns/1ps
module rsw_reset_sleep_wake
    import rsw_pkg::*;
(
    input  wire logic            I_CLOCK,
    input  wire logic            I_RESET,
    input  wire logic            I_BROWN_OUT,
    input  wire logic            I_MASTER_CLEAR_PIN_N,
    input  wire logic            I_WATCHDOG_TIMEOUT,
    input  wire logic            I_WATCHDOG_CLEAR_INSTR,
    input  wire logic            I_SLEEP_EXEC,
    input  wire logic [PC_W-1:0] I_PC,
    input  wire logic            I_INSTR_DONE,
    input  wire logic            I_GLOBAL_IRQ_ENABLE,
    input  wire rsw_irq_t        I_IRQ,
    input  wire logic            I_IMMUNE_LOADED,
    output logic                 O_CORE_RESET,
    output logic                 O_IMMUNE_UNDEFINED,
    output rsw_status_t          O_STATUS,
    output rsw_cause_t           O_CAUSE,
    output logic                 O_CAUSE_VALID,
    output logic                 O_WATCHDOG_CLEAR,
    output logic                 O_SLEEPING,
    output logic                 O_WAKE,
    output logic                 O_PREFETCH_REQ,
    output logic [PC_W-1:0]      O_PREFETCH_ADDR,
    output logic                 O_VECTOR_BRANCH,
    output logic [PC_W-1:0]      O_VECTOR_ADDR
);
    rsw_state_t  state_reg;
    rsw_state_t  state_next;
    rsw_status_t status_next;
    rsw_cause_t  cause_next;
    logic        pend_reg;
    logic        mclear_active;

    rsw_clear_filter u_clear_filter (
        .i_clock        (I_CLOCK),
        .i_reset        (I_RESET),
        .i_pin_n        (I_MASTER_CLEAR_PIN_N),
        .o_clear_active (mclear_active)
    );

    // priority: brown-out over master-clear over watchdog
    wire logic asleep      = state_reg == ST_SLEEP;
    wire logic irq_pend    = rsw_irq_pending(I_IRQ);
    wire logic brown_hit   = I_BROWN_OUT;
    wire logic mclear_hit  = !brown_hit && mclear_active;
    wire logic wdog_hit    = !brown_hit && !mclear_active && I_WATCHDOG_TIMEOUT;
    wire logic wdog_wake   = wdog_hit && asleep;
    wire logic wdog_reset  = wdog_hit && !asleep;
    wire logic any_reset   = brown_hit || mclear_hit || wdog_reset;
    // a held master-clear that began in sleep keeps its sleep cause
    wire logic mclear_slept = O_CAUSE == CAUSE_MCLEAR_SLEEP && O_CORE_RESET;
    wire logic sleep_take  = I_SLEEP_EXEC && state_reg == ST_RUN && !any_reset
                             && !wdog_hit;
    // pending means flagged in an earlier cycle, before the instruction ran
    wire logic sleep_nop   = sleep_take && pend_reg;
    wire logic sleep_enter = sleep_take && !pend_reg;
    // individual enables only; the global enable is not looked at here
    wire logic wake_irq    = asleep && irq_pend && !mclear_hit && !brown_hit
                             && !wdog_hit;
    wire logic vector_fire = state_reg == ST_WAKE && I_INSTR_DONE && !any_reset;
    // the watchdog wake is a resumption, so it never resets the core
    wire logic core_reset_next = any_reset;
    // watchdog reset has no path to the pin: this block only reads it
    wire logic pin_untouched = wdog_reset;
    wire logic cause_valid_next = brown_hit || mclear_hit || wdog_hit;
    wire logic wdog_clear_next = sleep_enter || (I_WATCHDOG_CLEAR_INSTR && !any_reset);
    wire logic immune_next = I_IMMUNE_LOADED ? 1'b0 : O_IMMUNE_UNDEFINED;
    wire logic [PC_W-1:0] prefetch_next = I_PC + PC_STEP;

    always_comb begin
        status_next = O_STATUS;
        cause_next  = O_CAUSE;
        if (brown_hit) begin
            status_next = STAT_BROWN;
            cause_next  = CAUSE_BROWN;
        end else if (mclear_hit) begin
            if (asleep || !mclear_slept) begin
                cause_next = asleep ? CAUSE_MCLEAR_SLEEP : CAUSE_MCLEAR_RUN;
            end
            if (asleep) begin
                status_next = STAT_MCLEAR_SLEEP;
            end
        end else if (wdog_hit) begin
            cause_next  = asleep ? CAUSE_WDOG_WAKE : CAUSE_WDOG_RESET;
            status_next = asleep ? STAT_WDOG_WAKE
                                 : rsw_status_t'({1'b0, O_STATUS.powerdown_status_bit});
        end else if (sleep_enter) begin
            status_next = STAT_SLEEP;
        end else if (I_WATCHDOG_CLEAR_INSTR) begin
            status_next = STAT_WDOG_CLEAR;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (sleep_enter) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (mclear_hit || brown_hit || wdog_hit) begin
                    state_next = ST_RUN;
                end else if (wake_irq) begin
                    state_next = I_GLOBAL_IRQ_ENABLE ? ST_WAKE : ST_RUN;
                end
            end
            ST_WAKE: begin
                if (any_reset || vector_fire) begin
                    state_next = ST_RUN;
                end
            end
            default: state_next = ST_RUN;
        endcase
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            state_reg <= ST_RUN;
            pend_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            pend_reg  <= irq_pend;
        end
    end

    // the synchronous reset input stands for the power-on event
    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            O_CORE_RESET       <= 1'b1;
            O_IMMUNE_UNDEFINED <= 1'b1;
            O_STATUS           <= STAT_POR;
            O_CAUSE            <= CAUSE_POR;
            O_CAUSE_VALID      <= 1'b1;
            O_WATCHDOG_CLEAR   <= 1'b0;
            O_SLEEPING         <= 1'b0;
            O_WAKE             <= 1'b0;
        end else begin
            O_CORE_RESET       <= core_reset_next;
            O_IMMUNE_UNDEFINED <= immune_next;
            O_STATUS           <= status_next;
            O_CAUSE            <= cause_next;
            O_CAUSE_VALID      <= cause_valid_next;
            O_WATCHDOG_CLEAR   <= wdog_clear_next;
            O_SLEEPING         <= state_next == ST_SLEEP;
            O_WAKE             <= asleep && state_next != ST_SLEEP && !mclear_hit && !brown_hit;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            O_PREFETCH_REQ  <= 1'b0;
            O_PREFETCH_ADDR <= '0;
            O_VECTOR_BRANCH <= 1'b0;
            O_VECTOR_ADDR   <= '0;
        end else begin
            O_PREFETCH_REQ  <= sleep_take;
            O_VECTOR_BRANCH <= vector_fire;
            if (sleep_take) begin
                O_PREFETCH_ADDR <= prefetch_next;
            end
            if (vector_fire) begin
                O_VECTOR_ADDR <= IRQ_VECTOR_ADDR;
            end
        end
    end

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RESET);

    a_wdog_wake_noreset: assert property (
        wdog_wake |=> !O_CORE_RESET && O_STATUS == STAT_WDOG_WAKE && O_WAKE)
        else $error("watchdog wake-up disturbed registers or status");

    a_wdog_run_reset: assert property (
        wdog_reset |=> O_CORE_RESET && O_CAUSE == CAUSE_WDOG_RESET
                       && !O_STATUS.timeout_status_bit)
        else $error("watchdog reset while running not reported");

    a_pin_input_only: assert property (
        pin_untouched && I_MASTER_CLEAR_PIN_N |=> !mclear_active)
        else $error("watchdog reset disturbed the master-clear path");

    a_mclear_sleep_stat: assert property (
        mclear_hit && asleep |=> O_STATUS == STAT_MCLEAR_SLEEP
                                 && O_CAUSE == CAUSE_MCLEAR_SLEEP && O_CORE_RESET)
        else $error("master-clear in sleep gave wrong status");

    a_mclear_sleep_held: assert property (
        mclear_hit && asleep ##1 mclear_hit |=> O_CAUSE == CAUSE_MCLEAR_SLEEP)
        else $error("held master-clear lost its sleep cause");

    a_mclear_run_keep: assert property (
        mclear_hit && !asleep && !mclear_slept
        |=> O_CAUSE == CAUSE_MCLEAR_RUN && O_STATUS == $past(O_STATUS) && O_CORE_RESET)
        else $error("master-clear while running changed status");

    a_brown_reset: assert property (
        brown_hit |=> O_CORE_RESET && O_CAUSE == CAUSE_BROWN && O_STATUS == STAT_BROWN)
        else $error("brown-out reset not reported");

    a_cause_valid_set: assert property (
        brown_hit || mclear_hit || wdog_hit |=> O_CAUSE_VALID)
        else $error("cause valid missing after a reset event");

    a_cause_onehot: assert property (
        O_CAUSE_VALID |-> $onehot(O_CAUSE))
        else $error("reported cause is not one-hot");

    a_status_hold: assert property (
        !brown_hit && !mclear_hit && !wdog_hit && !sleep_enter && !I_WATCHDOG_CLEAR_INSTR
        |=> $stable(O_STATUS))
        else $error("status bits moved with no event");

    a_wdog_clear_src: assert property (
        I_WATCHDOG_CLEAR_INSTR && !any_reset && !wdog_hit && !sleep_enter
        |=> O_WATCHDOG_CLEAR && O_STATUS == STAT_WDOG_CLEAR)
        else $error("watchdog clear instruction not honoured");

    a_sleep_nop_keep: assert property (
        sleep_nop |=> $stable(O_STATUS) && !O_WATCHDOG_CLEAR && !O_SLEEPING)
        else $error("power-save with pending interrupt was not a no-op");

    a_sleep_enter_clr: assert property (
        sleep_enter |=> O_WATCHDOG_CLEAR && O_STATUS == STAT_SLEEP && O_SLEEPING)
        else $error("power-save entry did not clear watchdog or set status");

    a_irq_wake_fast: assert property (
        sleep_enter && irq_pend && !I_BROWN_OUT && !I_WATCHDOG_TIMEOUT
        ##1 (irq_pend && !brown_hit && !mclear_hit && !wdog_hit) |=> O_WAKE && !O_SLEEPING)
        else $error("interrupt during power-save did not wake at once");

    a_masked_no_wake: assert property (
        asleep && !irq_pend && !I_WATCHDOG_TIMEOUT && !mclear_active && !I_BROWN_OUT
        |=> !O_WAKE && O_SLEEPING)
        else $error("woke without an enabled interrupt");

    a_wake_no_reset: assert property (
        O_WAKE |-> !O_CORE_RESET)
        else $error("wake-up came with a core reset");

    a_wake_pulse: assert property (
        O_WAKE |=> !O_WAKE)
        else $error("wake pulse longer than one cycle");

    a_wake_leaves_sleep: assert property (
        O_WAKE |-> !O_SLEEPING)
        else $error("still sleeping while waking");

    a_nop_prefetch: assert property (
        sleep_nop |=> O_PREFETCH_REQ)
        else $error("power-save as no-op skipped the prefetch");

    a_sleep_refused: assert property (
        I_SLEEP_EXEC && state_reg != ST_RUN |=> !O_PREFETCH_REQ)
        else $error("power-save honoured outside run state");

    a_vector_only_wake: assert property (
        state_reg != ST_WAKE |=> !O_VECTOR_BRANCH)
        else $error("vector branch outside wake state");

    a_vector_pulse: assert property (
        O_VECTOR_BRANCH |=> !O_VECTOR_BRANCH)
        else $error("vector branch longer than one cycle");

    a_immune_load: assert property (
        I_IMMUNE_LOADED |=> !O_IMMUNE_UNDEFINED)
        else $error("reset-immune load not seen");

    a_gie_vector: assert property (
        wake_irq && I_GLOBAL_IRQ_ENABLE ##1 (vector_fire)
        |=> O_VECTOR_BRANCH && O_VECTOR_ADDR == IRQ_VECTOR_ADDR)
        else $error("vector branch missing after wake with global enable");

    a_gie_inline: assert property (
        wake_irq && !I_GLOBAL_IRQ_ENABLE |=> state_reg == ST_RUN ##1 !O_VECTOR_BRANCH)
        else $error("wake with global enable clear branched to vector");

    a_prefetch_addr: assert property (
        sleep_take |=> O_PREFETCH_REQ && O_PREFETCH_ADDR == PC_W'($past(I_PC) + PC_STEP))
        else $error("prefetch address is not the next instruction");

    a_immune_kept: assert property (
        (brown_hit || mclear_hit || wdog_hit) && !I_IMMUNE_LOADED
        |=> $stable(O_IMMUNE_UNDEFINED))
        else $error("reset-immune state changed on a non power-on reset");

endmodule

/* testbench/rsw_core_model.sv */
`timescale 1ns/1ps
module rsw_core_model (
    input  wire logic       i_clock,
    input  wire logic       i_wake,
    input  wire logic [2:0] i_delay,
    output logic            o_instr_done
);
    logic [3:0] cnt_reg;
    initial begin
        cnt_reg      = 4'h0;
        o_instr_done = 1'b0;
    end
    // finishing the instruction after power-save takes a varying number of cycles after wake
    always @(negedge i_clock) begin
        o_instr_done <= (cnt_reg == 4'h1);
        if (i_wake) begin
            cnt_reg <= {1'b0, i_delay} + 4'h1;
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end
endmodule

/* testbench/test_reset_sleep_wake_control.sv */
`timescale 1ns/1ps
module test_reset_sleep_wake_control
    import rsw_pkg::*;
;
    logic            clk = 1'b0;
    logic            rst, brn, mclear_n, wdog, wclr, slp, done, g_en, imm;
    logic            core_rst, imm_undef, cval, wdclr, sleeping, wake, pf_req, vbr;
    logic [PC_W-1:0] pc, pf_addr, v_addr;
    logic [2:0]      dly;
    rsw_irq_t        irq;
    rsw_status_t     stat, exp_stat;
    rsw_cause_t      cause;
    int              err_total, n_checks;

    rsw_reset_sleep_wake DUT (.I_CLOCK(clk), .I_RESET(rst), .I_BROWN_OUT(brn),
        .I_MASTER_CLEAR_PIN_N(mclear_n), .I_WATCHDOG_TIMEOUT(wdog),
        .I_WATCHDOG_CLEAR_INSTR(wclr),
        .I_SLEEP_EXEC(slp), .I_PC(pc), .I_INSTR_DONE(done), .I_GLOBAL_IRQ_ENABLE(g_en),
        .I_IRQ(irq), .I_IMMUNE_LOADED(imm), .O_CORE_RESET(core_rst),
        .O_IMMUNE_UNDEFINED(imm_undef), .O_STATUS(stat), .O_CAUSE(cause),
        .O_CAUSE_VALID(cval), .O_WATCHDOG_CLEAR(wdclr), .O_SLEEPING(sleeping), .O_WAKE(wake),
        .O_PREFETCH_REQ(pf_req), .O_PREFETCH_ADDR(pf_addr), .O_VECTOR_BRANCH(vbr),
        .O_VECTOR_ADDR(v_addr));
    rsw_core_model MODEL (.i_clock(clk), .i_wake(wake), .i_delay(dly), .o_instr_done(done));

    always #4 clk = ~clk;

    task automatic cy(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic sleep_once(input logic pend, input logic by_wdog);
        logic [7:0] b;
        logic       vb;
        b = 8'h01 << ($urandom % 8);
        pc = PC_W'($urandom);
        g_en = 1'($urandom);
        dly = 3'($urandom);
        wclr = 1'b1;
        cy(1);
        wclr = 1'b0;
        chk({wdclr, 2'b00, stat}, {1'b1, 2'b00, STAT_WDOG_CLEAR});
        exp_stat = STAT_WDOG_CLEAR;
        if (pend) begin
            irq = {b, b};
            cy(1);
        end
        slp = 1'b1;
        cy(1);
        slp = 1'b0;
        chk({pf_req, 2'b00, pf_addr}, {1'b1, 2'b00, pc + PC_STEP});
        chk({wdclr, sleeping, stat}, {~pend, ~pend, pend ? exp_stat : STAT_SLEEP});
        if (!pend) begin
            // flagged but not individually enabled: must not wake
            irq = {b, ~b};
            cy(3);
            chk(sleeping, 1'b1);
            if (by_wdog) begin
                wdog = 1'b1;
                cy(1);
                wdog = 1'b0;
                chk({core_rst, wake, cval, cause, stat},
                    {3'b011, CAUSE_WDOG_WAKE, STAT_WDOG_WAKE});
            end else begin
                irq.enables = b;
                cy(1);
                chk({wake, sleeping, stat}, {2'b10, STAT_SLEEP});
            end
        end
        irq = '0;
        vb = 1'b0;
        repeat (12) begin
            cy(1);
            if (vbr === 1'b1) begin
                vb = 1'b1;
                chk(v_addr, IRQ_VECTOR_ADDR);
            end
        end
        chk(vb, g_en & ~pend & ~by_wdog);
    endtask

    task automatic mclear_pulse(input int n, input logic asleep);
        logic seen;
        seen = 1'b0;
        if (asleep) begin
            slp = 1'b1;
            cy(1);
            slp = 1'b0;
            exp_stat = STAT_MCLEAR_SLEEP;
        end
        mclear_n = 1'b0;
        repeat (n) begin
            cy(1);
            seen |= core_rst;
        end
        mclear_n = 1'b1;
        repeat (16) begin
            cy(1);
            seen |= core_rst;
        end
        chk(seen, n >= MCLEAR_FILTER_CYC);
        if (n >= MCLEAR_FILTER_CYC) begin
            chk({sleeping, cause, stat},
                {1'b0, asleep ? CAUSE_MCLEAR_SLEEP : CAUSE_MCLEAR_RUN, exp_stat});
        end
    endtask

    initial begin
        rst = 1'b1;
        {brn, wdog, wclr, slp, g_en, imm} = '0;
        mclear_n = 1'b1;
        pc = '0;
        irq = '0;
        dly = '0;
        err_total = 0;
        n_checks = 0;
        void'($urandom(32'h2af3));
        cy(4);
        chk({core_rst, imm_undef, cval, stat, cause},
            {3'b111, STAT_POR, CAUSE_POR});
        rst = 1'b0;
        cy(1);
        chk({core_rst, cval}, 2'b00);
        imm = 1'b1;
        cy(1);
        imm = 1'b0;
        chk(imm_undef, 1'b0);
        brn = 1'b1;
        cy(3);
        chk({core_rst, imm_undef, cause, stat},
            {2'b10, CAUSE_BROWN, STAT_BROWN});
        exp_stat = STAT_BROWN;
        brn = 1'b0;
        cy(2);
        wdog = 1'b1;
        cy(1);
        wdog = 1'b0;
        chk({core_rst, cause, stat},
            {1'b1, CAUSE_WDOG_RESET, 1'b0, exp_stat.powerdown_status_bit});
        exp_stat.timeout_status_bit = 1'b0;
        cy(1);
        chk(core_rst, 1'b0);
        mclear_pulse(MCLEAR_FILTER_CYC - 1, 1'b0);
        mclear_pulse(MCLEAR_FILTER_CYC + 2, 1'b0);
        mclear_pulse(MCLEAR_FILTER_CYC + 2, 1'b1);
        for (int i = 0; i < 12; i++) begin
            sleep_once(1'($urandom), i % 3 == 2);
        end
        chk(imm_undef, 1'b0);
        report_and_stop();
    end
endmodule
